// ==== dos_pkg.sv ====
package dos_pkg;

  // Three-state order select, already resolved by the pin comparators
  typedef enum logic [1:0] {
    DOS_ORD_RAIL  = 2'h0,
    DOS_ORD_GND   = 2'h1,
    DOS_ORD_FLOAT = 2'h2
  } dos_order_e;

  // Sequencer states, Gray coded along the start path
  typedef enum logic [2:0] {
    DOS_ST_OFF    = 3'h0,
    DOS_ST_BIAS   = 3'h1,
    DOS_ST_RUN    = 3'h3
  } dos_state_e;

  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned SEQ_DELAY_US   = 400;
  localparam int unsigned SEQ_DELAY_CYC  = (SEQ_DELAY_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SS_TIME_US     = 2100;
  localparam int unsigned SS_TIME_CYC    = (SS_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned SS_STEPS       = 64;
  localparam int unsigned SS_STEP_CYC    = SS_TIME_CYC / SS_STEPS;
  localparam int unsigned SKIP_PULSES    = 6;
  localparam int unsigned REF_W          = 6;
  localparam logic [REF_W-1:0] REF_FULL  = 6'h3F;

  // Per-channel inputs from the analog side
  typedef struct packed {
    logic enable_n;
    logic overcurrent;
  } dos_chan_in_s;

  // Per-channel control outputs
  typedef struct packed {
    logic             pwm_gate;
    logic             high_side_on;
    logic             pulldown_on;
    logic             ramp_done;
    logic [REF_W-1:0] ref_level;
  } dos_chan_out_s;

endpackage

// ==== dos_softstart.sv ====
`timescale 1ns/100ps
module dos_softstart
  import dos_pkg::*;
#(
  parameter int unsigned STEP_CYC = dos_pkg::SS_STEP_CYC,
  parameter int unsigned SKIP_N   = dos_pkg::SKIP_PULSES
) (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  // Control
  input  wire logic                     run_i,
  input  wire logic                     slot_i,
  input  wire logic                     overcurrent_i,
  // Status
  output logic                          pwm_o,
  output logic                          done_o,
  output logic [dos_pkg::REF_W-1:0]     ref_o
);
  initial begin
    if (STEP_CYC < 1 || STEP_CYC > 65536 || SKIP_N < 1 || SKIP_N > 15) begin
      $error("dos_softstart parameters out of range");
    end
  end

  typedef struct packed {
    logic [REF_W-1:0] ref_lvl;
    logic [15:0]      step_cnt;
    logic [3:0]       skip_cnt;
    logic             pwm;
    logic             done;
  } dos_ss_s;

  dos_ss_s st_ff;
  dos_ss_s nxt_st;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.pwm = 1'b0;
    if (!run_i) begin
      nxt_st = '0;
    end else begin
      if (st_ff.ref_lvl != REF_FULL) begin
        if (st_ff.step_cnt == 16'(STEP_CYC - 1)) begin
          nxt_st.step_cnt = '0;
          nxt_st.ref_lvl  = st_ff.ref_lvl + 1'b1;
        end else begin
          nxt_st.step_cnt = st_ff.step_cnt + 1'b1;
        end
      end else begin
        nxt_st.done = 1'b1;
      end
      if (slot_i) begin
        if (st_ff.skip_cnt != 4'h0) begin
          nxt_st.skip_cnt = st_ff.skip_cnt - 1'b1;
        end else begin
          nxt_st.pwm = 1'b1;
        end
      end
      // Overcurrent only loads the skip count while the ramp is still climbing
      if (overcurrent_i && !st_ff.done) begin
        nxt_st.skip_cnt = 4'(SKIP_N);
        nxt_st.pwm      = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign pwm_o  = st_ff.pwm;
  assign done_o = st_ff.done;
  assign ref_o  = st_ff.ref_lvl;
endmodule // dos_softstart

// ==== dos_delay.sv ====
`timescale 1ns/100ps
module dos_delay #(
  parameter int unsigned DELAY_CYC = dos_pkg::SEQ_DELAY_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // Start and expiry
  input  wire logic start_i,
  output logic      expired_o
);
  initial begin
    if (DELAY_CYC < 1 || DELAY_CYC > 65535) begin
      $error("dos_delay DELAY_CYC out of range");
    end
  end

  typedef struct packed {
    logic [15:0] cnt;
    logic        expired;
  } dos_dly_s;

  dos_dly_s st_ff;
  dos_dly_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!start_i) begin
      nxt_st = '0;
    end else if (st_ff.cnt == 16'(DELAY_CYC - 1)) begin
      nxt_st.expired = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  assign expired_o = st_ff.expired;
endmodule // dos_delay

// ==== dos_sequencer.sv ====
// Function
// - Each channel has an active-low enable; low enables it and starts soft start.
// - An undriven enable reads high, so the channel stays off.
// - Both enables high puts the device in shutdown with bias regulator off.
// - Deasserting a running master or floating-mode channel turns its high side off; pulldown stays off.
// - Order select is caught at power-on: rail, ground or floating.
// - Rail mode: output 1 starts about 400 us after output 2 regulates.
// - Rail mode: output 2 enable high after running disables both outputs.
// - Rail mode: output 1 enable ignored while output 2 on; else it holds bias.
// - Ground mode: output 2 starts about 400 us after output 1 regulates.
// - Ground mode: output 1 enable high after running disables both outputs.
// - Ground mode: output 2 enable ignored while output 1 on; else holds bias.
// - Floating mode with enables tied: both ramps run together, finish together.
// - Floating mode with separate enables: each channel follows its own enable.
// - Soft start steps the reference from zero to full over about 2.1 ms.
// - An overcurrent during soft start suppresses the next six PWM pulses.
// - No pulse is skipped unless an overcurrent was actually seen.
// - Channels switch on alternate oscillator cycles, half a period apart.
// - PWM and soft start only after the bias rail reports good.
`timescale 1ns/100ps
module dos_sequencer
  import dos_pkg::*;
#(
  parameter int unsigned SEQ_DELAY = dos_pkg::SEQ_DELAY_CYC,
  parameter int unsigned STEP_CYC  = dos_pkg::SS_STEP_CYC
) (
  // Clock and reset
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  // Supply status
  input  wire logic                  control_supply_ok_i,
  input  wire logic                  internal_bias_rail_good_i,
  input  wire logic                  osc_tick_i,
  // Sequence select and enables
  input  wire dos_pkg::dos_order_e   startup_order_select_i,
  input  wire logic                  output1_enable_n_i,
  input  wire logic                  output1_enable_n_oe_i,
  input  wire logic                  output2_enable_n_i,
  input  wire logic                  output2_enable_n_oe_i,
  input  wire logic [1:0]            overcurrent_i,
  // Channel controls
  output dos_pkg::dos_chan_out_s     chan1_o,
  output dos_pkg::dos_chan_out_s     chan2_o,
  output logic                       bias_regulator_on_o,
  output logic                       shutdown_o,
  output dos_pkg::dos_order_e        order_o
);
  import dos_pkg::*;

  initial begin
    if (SEQ_DELAY < 1 || STEP_CYC < 1) begin
      $error("dos_sequencer parameters out of range");
    end
  end

  typedef struct packed {
    logic          captured;
    dos_order_e    order;
    dos_state_e    state;
    logic          phase;
    logic [1:0]    ran;
    dos_chan_out_s ch1;
    dos_chan_out_s ch2;
    logic          bias_on;
    logic          shdn;
  } dos_top_s;

  dos_top_s st_ff;
  dos_top_s nxt_st;
  logic     rst_sync_n;

  // Enables that are not driven read as high
  logic en1;
  logic en2;
  assign en1 = output1_enable_n_oe_i & ~output1_enable_n_i;
  assign en2 = output2_enable_n_oe_i & ~output2_enable_n_i;

  // Reset release synchroniser kept outside the main struct
  logic [1:0] rsync_ff;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsync_ff <= 2'h0;
    end else begin
      rsync_ff <= {rsync_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rsync_ff[1];

  logic run1;
  logic run2;
  logic slot1;
  logic slot2;
  logic done1;
  logic done2;
  logic pwm1;
  logic pwm2;
  logic dly_start;
  logic dly_exp;
  logic [REF_W-1:0] ref1;
  logic [REF_W-1:0] ref2;
  logic bias_ok;

  assign bias_ok = st_ff.state == DOS_ST_RUN && internal_bias_rail_good_i;
  assign slot1   = osc_tick_i & ~st_ff.phase;
  assign slot2   = osc_tick_i & st_ff.phase;

  // Enable decode per captured order
  always_comb begin
    run1      = 1'b0;
    run2      = 1'b0;
    dly_start = 1'b0;
    if (bias_ok) begin
      unique case (st_ff.order)
        DOS_ORD_RAIL: begin
          run2      = en2;
          dly_start = en2 & done2;
          run1      = dly_start & dly_exp;
        end
        DOS_ORD_GND: begin
          run1      = en1;
          dly_start = en1 & done1;
          run2      = dly_start & dly_exp;
        end
        default: begin
          // Tied enables start both ramps on the same edge, so they finish together
          run1 = en1;
          run2 = en2;
        end
      endcase
    end
  end

  always_comb begin
    nxt_st          = st_ff;
    if (!st_ff.captured && control_supply_ok_i) begin
      nxt_st.captured = 1'b1;
      nxt_st.order    = startup_order_select_i;
    end
    if (osc_tick_i) begin
      nxt_st.phase = ~st_ff.phase;
    end
    // Bias demand per mode; slave enable can hold bias while master is off
    unique case (st_ff.order)
      DOS_ORD_RAIL:  nxt_st.bias_on = en2 | en1;
      DOS_ORD_GND:   nxt_st.bias_on = en1 | en2;
      default:       nxt_st.bias_on = en1 | en2;
    endcase
    if (!control_supply_ok_i || !st_ff.captured) begin
      nxt_st.bias_on = 1'b0;
    end
    nxt_st.shdn = ~nxt_st.bias_on;
    unique case (st_ff.state)
      DOS_ST_OFF:  if (nxt_st.bias_on) nxt_st.state = DOS_ST_BIAS;
      DOS_ST_BIAS: if (!nxt_st.bias_on) nxt_st.state = DOS_ST_OFF;
                   else if (internal_bias_rail_good_i) nxt_st.state = DOS_ST_RUN;
      DOS_ST_RUN:  if (!nxt_st.bias_on) nxt_st.state = DOS_ST_OFF;
      default:     nxt_st.state = DOS_ST_OFF;
    endcase
    nxt_st.ran              = {run2, run1};
    nxt_st.ch1.pwm_gate     = pwm1 & run1;
    nxt_st.ch1.high_side_on = pwm1 & run1;
    nxt_st.ch1.pulldown_on  = 1'b0;
    nxt_st.ch1.ramp_done    = done1;
    nxt_st.ch1.ref_level    = ref1;
    nxt_st.ch2.pwm_gate     = pwm2 & run2;
    nxt_st.ch2.high_side_on = pwm2 & run2;
    nxt_st.ch2.pulldown_on  = 1'b0;
    nxt_st.ch2.ramp_done    = done2;
    nxt_st.ch2.ref_level    = ref2;
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_ff       <= '0;
      st_ff.order <= DOS_ORD_FLOAT;
      st_ff.shdn  <= 1'b1;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  dos_softstart #(.STEP_CYC(STEP_CYC), .SKIP_N(SKIP_PULSES)) u_ss1 (
    .clk_i         (ref_clk_i),
    .rst_n_i       (rst_sync_n),
    .ce_i          (ce_i),
    .run_i         (run1),
    .slot_i        (slot1),
    .overcurrent_i (overcurrent_i[0]),
    .pwm_o         (pwm1),
    .done_o        (done1),
    .ref_o         (ref1)
  );

  dos_softstart #(.STEP_CYC(STEP_CYC), .SKIP_N(SKIP_PULSES)) u_ss2 (
    .clk_i         (ref_clk_i),
    .rst_n_i       (rst_sync_n),
    .ce_i          (ce_i),
    .run_i         (run2),
    .slot_i        (slot2),
    .overcurrent_i (overcurrent_i[1]),
    .pwm_o         (pwm2),
    .done_o        (done2),
    .ref_o         (ref2)
  );

  dos_delay #(.DELAY_CYC(SEQ_DELAY)) u_dly (
    .clk_i     (ref_clk_i),
    .rst_n_i   (rst_sync_n),
    .ce_i      (ce_i),
    .start_i   (dly_start),
    .expired_o (dly_exp)
  );

  assign chan1_o             = st_ff.ch1;
  assign chan2_o             = st_ff.ch2;
  assign bias_regulator_on_o = st_ff.bias_on;
  assign shutdown_o          = st_ff.shdn;
  assign order_o             = st_ff.order;
endmodule // dos_sequencer

// ==== dos_sequencer_properties.sv ====
`timescale 1ns/100ps
module dos_sequencer_checker
  import dos_pkg::*;
(
  input wire logic                  ref_clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  control_supply_ok_i,
  input wire logic                  output1_enable_n_i,
  input wire logic                  output1_enable_n_oe_i,
  input wire logic                  output2_enable_n_i,
  input wire logic                  output2_enable_n_oe_i,
  input wire dos_pkg::dos_chan_out_s chan1_o,
  input wire dos_pkg::dos_chan_out_s chan2_o,
  input wire logic                  bias_regulator_on_o,
  input wire logic                  shutdown_o,
  input wire dos_pkg::dos_order_e   order_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // A released pin reads as disabled
  logic en1_on;
  logic en2_on;
  assign en1_on = output1_enable_n_oe_i && !output1_enable_n_i;
  assign en2_on = output2_enable_n_oe_i && !output2_enable_n_i;
  sequence s_both_dark;
    ##[1:2] (!chan1_o.high_side_on && !chan2_o.high_side_on);
  endsequence
  a_shutdown_mirror: assert property (shutdown_o == !bias_regulator_on_o)
    else $error("shutdown not inverse of bias");
  a_idle_shutdown: assert property (!en1_on && !en2_on |=> shutdown_o)
    else $error("no enable but not shut down");
  a_bias_follows: assert property ((en1_on || en2_on) && control_supply_ok_i && $past(rst_n_i, 3) |=> bias_regulator_on_o)
    else $error("enable did not start bias");
  a_rail_master_off: assert property (order_o == DOS_ORD_RAIL && !en2_on |-> s_both_dark)
    else $error("rail mode outputs still on");
  a_gnd_master_off: assert property (order_o == DOS_ORD_GND && !en1_on |-> s_both_dark)
    else $error("ground mode outputs still on");
  a_float_own_enable: assert property (order_o == DOS_ORD_FLOAT && !en1_on |-> ##[1:2] !chan1_o.high_side_on)
    else $error("channel 1 on without its enable");
  a_pulldown_never: assert property (!chan1_o.pulldown_on && !chan2_o.pulldown_on)
    else $error("pulldown switched on");
  a_done_at_full: assert property (chan1_o.ramp_done || chan2_o.ramp_done |-> (!chan1_o.ramp_done || chan1_o.ref_level == REF_FULL) && (!chan2_o.ramp_done || chan2_o.ref_level == REF_FULL))
    else $error("ramp done below full");
  a_ramp_steps: assert property ($changed(chan1_o.ref_level) |-> chan1_o.ref_level == $past(chan1_o.ref_level) + 6'h01 || chan1_o.ref_level == 6'h00)
    else $error("ramp jumped");
  a_alternate_slots: assert property (!(chan1_o.pwm_gate && chan2_o.pwm_gate))
    else $error("both channels pulse together");
  a_pwm_needs_bias: assert property (chan1_o.pwm_gate || chan2_o.pwm_gate |-> bias_regulator_on_o || $past(bias_regulator_on_o))
    else $error("pulse without bias");
endmodule // dos_sequencer_checker
bind dos_sequencer dos_sequencer_checker chk_u (.ref_clk_i, .rst_n_i, .control_supply_ok_i, .output1_enable_n_i,
  .output1_enable_n_oe_i, .output2_enable_n_i, .output2_enable_n_oe_i, .chan1_o, .chan2_o, .bias_regulator_on_o,
  .shutdown_o, .order_o);

// ==== dos_sys_model.sv ====
`timescale 1ns/100ps
module dos_sys_model (
  // Clock and commands
  input  wire logic       clk_i,
  input  wire logic       bias_on_i,
  input  wire logic [1:0] en1_mode_i,
  input  wire logic [1:0] en2_mode_i,
  // Rails and pins
  output logic            bias_good_o,
  output logic            tick_o,
  output logic            en1_n_o,
  output logic            en1_oe_o,
  output logic            en2_n_o,
  output logic            en2_oe_o
);
  // Mode 0 drives low, 1 drives high, 2 releases the pin
  logic [2:0] cnt_ff = 3'h0;
  logic [1:0] div_ff = 2'h0;
  always_ff @(posedge clk_i) begin
    cnt_ff <= bias_on_i ? ((cnt_ff == 3'h4) ? cnt_ff : cnt_ff + 3'h1) : 3'h0;
    div_ff <= div_ff + 2'h1;
  end
  // The rail charges for a few cycles before it reads good
  assign bias_good_o = (cnt_ff == 3'h4);
  assign tick_o      = (div_ff == 2'h3);
  // A released pin sits at its pull-up level
  assign en1_n_o     = (en1_mode_i != 2'h0);
  assign en1_oe_o    = (en1_mode_i != 2'h2);
  assign en2_n_o     = (en2_mode_i != 2'h0);
  assign en2_oe_o    = (en2_mode_i != 2'h2);
endmodule // dos_sys_model

// ==== tb_dual_output_enable_sequencer.sv ====
`timescale 1ns/100ps
module tb_dual_output_enable_sequencer;
  import dos_pkg::*;
  localparam int unsigned DLY = 20;
  localparam int unsigned STP = 4;
  logic          ref_clk_i = 1'b0;
  logic          rst_n_i   = 1'b0;
  logic          sup_ok    = 1'b0;
  logic [1:0]    oc        = 2'h0;
  logic [1:0]    m1        = 2'h1;
  logic [1:0]    m2        = 2'h1;
  dos_order_e    sel       = DOS_ORD_FLOAT;
  logic          good, tick, e1, e1oe, e2, e2oe, bias_on, shdn;
  dos_chan_out_s c1, c2;
  dos_order_e    ord;
  int            fail_count = 0;
  int            check_count = 0;
  always #12.5 ref_clk_i = ~ref_clk_i;
  dos_sys_model sys_u (.clk_i(ref_clk_i), .bias_on_i(bias_on), .en1_mode_i(m1), .en2_mode_i(m2),
    .bias_good_o(good), .tick_o(tick), .en1_n_o(e1), .en1_oe_o(e1oe), .en2_n_o(e2), .en2_oe_o(e2oe));
  dos_sequencer #(.SEQ_DELAY(DLY), .STEP_CYC(STP)) dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .control_supply_ok_i(sup_ok), .internal_bias_rail_good_i(good), .osc_tick_i(tick),
    .startup_order_select_i(sel), .output1_enable_n_i(e1), .output1_enable_n_oe_i(e1oe),
    .output2_enable_n_i(e2), .output2_enable_n_oe_i(e2oe), .overcurrent_i(oc), .chan1_o(c1), .chan2_o(c2),
    .bias_regulator_on_o(bias_on), .shutdown_o(shdn), .order_o(ord));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Bounded wait: 0/1 ramp done on channel 1/2, 2/3 ramp left zero
  task automatic wait_for(input int what, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (hit !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
      n++;
      case (what)
        0: hit = c1.ramp_done;
        1: hit = c2.ramp_done;
        2: hit = (c1.ref_level != 6'h00);
        default: hit = (c2.ref_level != 6'h00);
      endcase
      if (n > 2000) begin
        fail_count++;
        results();
      end
    end
  endtask
  task automatic pulses(input int cyc, output int p);
    logic prev;
    p = 0;
    prev = c1.pwm_gate;
    repeat (cyc) begin
      @(posedge ref_clk_i);
      #1;
      if (c1.pwm_gate === 1'b1 && prev !== 1'b1) p++;
      prev = c1.pwm_gate;
    end
  endtask
  // Order select is caught only once after reset, so every scenario resets
  task automatic start(input dos_order_e mode);
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    sup_ok <= 1'b0;
    sel <= mode;
    m1 <= 2'h1;
    m2 <= 2'h1;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    sup_ok <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(ord, mode);
  endtask
  task automatic seq_test(input dos_order_e mode);
    int n;
    bit rail;
    rail = (mode == DOS_ORD_RAIL);
    start(mode);
    @(posedge ref_clk_i);
    m1 <= 2'h0;
    m2 <= 2'h0;
    wait_for(rail ? 1 : 0, n);
    chk(rail ? c1.ref_level : c2.ref_level, 8'h00);
    wait_for(rail ? 2 : 3, n);
    chk(n >= DLY && n <= DLY + 2 * STP + 4, 1'b1);
    @(posedge ref_clk_i);
    if (rail) m1 <= 2'h1;
    else m2 <= 2'h1;
    wait_for(rail ? 0 : 1, n);
    chk({c1.ramp_done, c2.ramp_done}, 8'h03);
    @(posedge ref_clk_i);
    if (rail) m2 <= 2'h1;
    else m1 <= 2'h1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({c1.high_side_on, c2.high_side_on, shdn}, 8'h01);
    @(posedge ref_clk_i);
    if (rail) m1 <= 2'h0;
    else m2 <= 2'h0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk({bias_on, c1.high_side_on, c2.high_side_on}, 8'h04);
    $display("sequential test done");
  endtask
  task automatic tied_test();
    int n;
    start(DOS_ORD_FLOAT);
    @(posedge ref_clk_i);
    m1 <= 2'h0;
    m2 <= 2'h0;
    wait_for(0, n);
    chk(c2.ramp_done, 1'b1);
    chk(n >= 63 * STP && n <= 64 * STP + 12, 1'b1);
    chk(c1.ref_level, REF_FULL);
    $display("tied test done");
  endtask
  task automatic indep_test();
    int p;
    start(DOS_ORD_FLOAT);
    @(posedge ref_clk_i);
    m1 <= 2'h0;
    repeat (60) @(posedge ref_clk_i);
    pulses(40, p);
    chk(p != 0, 1'b1);
    @(posedge ref_clk_i);
    oc <= 2'h1;
    @(posedge ref_clk_i);
    oc <= 2'h0;
    pulses(40, p);
    chk(p, 8'h00);
    pulses(24, p);
    chk(p != 0, 1'b1);
    chk({c2.ref_level, c2.high_side_on}, 8'h00);
    @(posedge ref_clk_i);
    m1 <= 2'h1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk({c1.high_side_on, c1.pulldown_on, c2.pulldown_on}, 8'h00);
    $display("independent test done");
  endtask
  task automatic pin_test();
    start(DOS_ORD_FLOAT);
    @(posedge ref_clk_i);
    m1 <= 2'h2;
    m2 <= 2'h2;
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk({shdn, c1.high_side_on, c2.high_side_on}, 8'h04);
    @(posedge ref_clk_i);
    m2 <= 2'h0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk({bias_on, shdn}, 8'h02);
    $display("pin test done");
  endtask
  initial begin
    seq_test(DOS_ORD_RAIL);
    seq_test(DOS_ORD_GND);
    tied_test();
    indep_test();
    pin_test();
    results();
  end
endmodule // tb_dual_output_enable_sequencer
